// ===== dv/tsched_bench.sv
// Self-checking bench: APB set-up, trigger edges, periodic requests.
// Assumes the engine model in dv/ and a shortened 8-cycle timebase.
`timescale 1ns/1ps
`include "tsched_consts.svh"
module tsched_bench;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [7:0]  contacts;
  logic [15:0] int_cond;
  logic        scan_end, task_done, init_done, slow;
  logic        task_start, task_resume, scan_start, scan_resume;
  logic        scan_hold, init_phase, run_mode;
  logic [5:0]  task_id;
  int          err_count, n_compared;

  tsched_top #(.TICK_CYCLES(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .trigger_input_contacts(contacts), .int_cond(int_cond),
    .scan_end(scan_end), .task_done(task_done), .init_done(init_done),
    .task_start(task_start), .task_resume(task_resume),
    .task_id(task_id), .scan_start(scan_start),
    .scan_resume(scan_resume), .scan_hold(scan_hold),
    .init_phase(init_phase), .run_mode(run_mode));

  tsched_engine_model engine (
    .pclk(pclk), .presetn(presetn), .slow(slow),
    .task_start(task_start), .task_resume(task_resume),
    .task_done(task_done));

  // Clock at 40 MHz
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task test_done;
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  // One APB transfer; waits for pready with no assumed latency
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for a pulse: 0 task start, 1 scan start, 2 scan resume,
  // 3 task resume
  task await_pulse(input int kind, input int bound, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < bound && !seen; i++)
    begin
      @(posedge pclk);
      seen = (kind == 0) ? task_start :
             (kind == 1) ? scan_start :
             (kind == 2) ? scan_resume : task_resume;
    end
  endtask

  logic seen;
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {contacts, int_cond, scan_end, init_done, slow} = '0;
    err_count  = 0;
    n_compared = 0;
    presetn    = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk("init_phase", 32'h1, {31'h0, init_phase});
    apb(1'b0, `TSCHED_CMD_OFS, 32'h0);
    chk("global allow", 32'h1, {31'h0, rd[0]});
    apb(1'b0, 12'h0fc, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, `TSCHED_CTRL_OFS, 32'h1);
    @(posedge pclk);
    chk("run_mode", 32'h1, {31'h0, run_mode});
    // Init completion command releases the scan
    @(posedge pclk) init_done <= 1'b1;
    @(posedge pclk) init_done <= 1'b0;
    await_pulse(1, 4, seen);
    chk("scan_start", 32'h1, {31'h0, seen});
    // Tasks 16 and 17 share contact 8 on rising edges, prio 2 and 3
    apb(1'b1, `TSCHED_PRIO_BASE + 12'h040, 32'h2);
    apb(1'b1, `TSCHED_PRIO_BASE + 12'h044, 32'h3);
    apb(1'b1, `TSCHED_ECFG_BASE, 32'h1);
    apb(1'b1, `TSCHED_ECFG_BASE + 12'h004, 32'h1);
    slow     <= 1'b1;
    contacts <= 8'h01;
    await_pulse(0, 2000, seen);
    chk("first grant", 32'h10, {26'h0, task_id});
    chk("scan_hold", 32'h1, {31'h0, scan_hold});
    // Re-trigger while 16 runs and 17 waits: both must be dropped
    repeat (3) @(posedge pclk);
    contacts <= 8'h00;
    repeat (4) @(posedge pclk);
    contacts <= 8'h01;
    await_pulse(0, 200, seen);
    chk("pending grant", 32'h11, {26'h0, task_id});
    await_pulse(2, 200, seen);
    chk("scan_resume", 32'h1, {31'h0, seen});
    // Stop mode: edges must raise nothing
    apb(1'b1, `TSCHED_CTRL_OFS, 32'h0);
    contacts <= 8'h00;
    repeat (4) @(posedge pclk);
    contacts <= 8'h01;
    await_pulse(0, 100, seen);
    chk("stop edge", 32'h0, {31'h0, seen});
    // Periodic task 0, 1 ms period on the short timebase
    apb(1'b1, `TSCHED_CTRL_OFS, 32'h1);
    // Internal condition taken at scan end; next scan waits for it
    int_cond <= 16'h0001;
    apb(1'b1, `TSCHED_IEN_OFS, 32'h1);
    @(posedge pclk) scan_end <= 1'b1;
    @(posedge pclk) scan_end <= 1'b0;
    await_pulse(0, 20, seen);
    chk("internal grant", 32'h18, {26'h0, task_id});
    await_pulse(1, 30, seen);
    chk("early scan", 32'h0, {31'h0, seen});
    await_pulse(1, 200, seen);
    chk("scan after tasks", 32'h1, {31'h0, seen});
    apb(1'b1, `TSCHED_PERIOD_BASE, 32'h1);
    await_pulse(0, 100, seen);
    chk("periodic grant", 32'h0, {26'h0, task_id});
    chk("periodic seen", 32'h1, {31'h0, seen});
    // Contact edge preempts task 0; 17 follows, then 0 resumes
    contacts <= 8'h00;
    repeat (4) @(posedge pclk);
    contacts <= 8'h01;
    await_pulse(0, 200, seen);
    chk("preempting grant", 32'h10, {26'h0, task_id});
    await_pulse(0, 200, seen);
    chk("second grant", 32'h11, {26'h0, task_id});
    await_pulse(3, 200, seen);
    chk("resumed task", 32'h0, {26'h0, task_id});
    chk("resume seen", 32'h1, {31'h0, seen});
    test_done();
  end

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial
  begin
    #(25 * 20000);
    err_count++;
    test_done();
  end
endmodule

// ===== dv/tsched_engine_model.sv
// Behavioural program-execution engine facing the scheduler.
// Assumes one pclk domain; runs each granted task for a fixed time.
`timescale 1ns/1ps
module tsched_engine_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic task_start,
  input  wire logic task_resume,
  output logic      task_done
);
  logic [7:0] cnt_reg;

  // Restart the run time on every grant; a preempted task reruns it
  // in full, a pessimistic but legal stretch of its running time.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg   <= 8'h00;
      task_done <= 1'b0;
    end
    else
    begin
      task_done <= (cnt_reg == 8'h01);
      if (task_start || task_resume)
        cnt_reg <= slow ? 8'h28 : 8'h04;
      else if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule

// ===== inc/tsched_consts.svh
// Register map, field positions, reset values and timing counts of the
// task scheduler. Definitions only; included by the bench, the timebase and the top.
`ifndef TSCHED_CONSTS_SVH
`define TSCHED_CONSTS_SVH

// Byte offsets on the APB window (12-bit address)
`define TSCHED_CTRL_OFS    12'h000
`define TSCHED_CMD_OFS     12'h004
`define TSCHED_STATUS_OFS  12'h008
`define TSCHED_PEND_LO_OFS 12'h00c
`define TSCHED_PEND_HI_OFS 12'h010
`define TSCHED_ALLOW_LO_OFS 12'h014
`define TSCHED_ALLOW_HI_OFS 12'h018
`define TSCHED_IEN_OFS     12'h01c
`define TSCHED_PRIO_BASE   12'h040
`define TSCHED_PERIOD_BASE 12'h100
`define TSCHED_ECFG_BASE   12'h140

// Command register fields
`define TSCHED_CMD_ID_LSB  0
`define TSCHED_CMD_TALLOW  8
`define TSCHED_CMD_TBLOCK  9
`define TSCHED_CMD_GALLOW  10
`define TSCHED_CMD_GBLOCK  11

// Edge configuration fields
`define TSCHED_ECFG_MODE_LSB 0
`define TSCHED_ECFG_SEL_LSB  2

// Priority limits and reset values
`define TSCHED_PRIO_MIN    3'h2
`define TSCHED_PRIO_MAX    3'h7
`define TSCHED_PRIO_RST    3'h7
`define TSCHED_PERIOD_RST  32'h0000_0000

// Timing: 1 ms timebase, 50 us edge detection bound, 40 MHz clock
`define TSCHED_CLK_KHZ     40000
`define TSCHED_TICK_MS     1
`define TSCHED_TICK_CYC    (`TSCHED_TICK_MS * `TSCHED_CLK_KHZ)
`define TSCHED_EDGE_US     50
`define TSCHED_EDGE_CYC    ((`TSCHED_EDGE_US * `TSCHED_CLK_KHZ) / 1000)

`endif

// ===== inc/tsched_pkg.sv
// Types shared by the task scheduler modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tsched_pkg;

  // Scheduler phase, one-hot
  typedef enum logic [2:0] {
    TSCHED_PH_INIT = 3'b001,
    TSCHED_PH_SCAN = 3'b010,
    TSCHED_PH_END  = 3'b100
  } tsched_phase_t;

  // Edge condition of an external-input task
  typedef enum logic [1:0] {
    TSCHED_EDGE_OFF  = 2'h0,
    TSCHED_EDGE_RISE = 2'h1,
    TSCHED_EDGE_FALL = 2'h2,
    TSCHED_EDGE_BOTH = 2'h3
  } tsched_edge_t;

endpackage

// ===== rtl/tsched_edge.sv
// Synchronises the trigger contacts and detects the configured edges.
// Assumes raw asynchronous pins; config comes from the pclk domain.
`timescale 1ns/1ps
module tsched_edge #(
  parameter int NCH = 8
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic [NCH-1:0]                 contact_pin,
  input  wire logic                           run_en,
  input  wire logic [NCH-1:0][1:0]            cfg_mode,
  input  wire logic [NCH-1:0][$clog2(NCH)-1:0] cfg_sel,
  output logic      [NCH-1:0]                 edge_req
);
  typedef struct packed {
    logic [NCH-1:0] s1;
    logic [NCH-1:0] s2;
    logic [NCH-1:0] prev;
    logic [NCH-1:0] req;
  } tsched_edge_st_t;

  tsched_edge_st_t st_reg;
  tsched_edge_st_t st_next;
  logic [NCH-1:0]  rise;
  logic [NCH-1:0]  fall;

  // Two-stage sync, then compare against the previous synced level
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = contact_pin;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    rise = st_reg.s2 & ~st_reg.prev;
    fall = ~st_reg.s2 & st_reg.prev;
    for (int i = 0; i < NCH; i++)
    begin
      case (tsched_pkg::tsched_edge_t'(cfg_mode[i]))
        tsched_pkg::TSCHED_EDGE_RISE: st_next.req[i] = rise[cfg_sel[i]]; // R7
        tsched_pkg::TSCHED_EDGE_FALL: st_next.req[i] = fall[cfg_sel[i]]; // R7
        tsched_pkg::TSCHED_EDGE_BOTH:
          st_next.req[i] = rise[cfg_sel[i]] | fall[cfg_sel[i]]; // R7
        default: st_next.req[i] = 1'b0;
      endcase
      // No monitoring in stop mode
      st_next.req[i] = st_next.req[i] & run_en; // R10
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign edge_req = st_reg.req;

  a_edge_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !run_en |=> edge_req == '0) else $error("edge request in stop"); // R10
  a_edge_rise_fast: assert property (@(posedge pclk) disable iff (!presetn)
    run_en && cfg_mode[0] == 2'h1 && rise[cfg_sel[0]] |=> edge_req[0])
    else $error("rising edge not requested"); // R11
endmodule

// ===== rtl/tsched_tick.sv
// Millisecond timebase for the periodic task timers.
// Assumes pclk at the rate the cycle count was derived for.
`timescale 1ns/1ps
`include "tsched_consts.svh"
module tsched_tick #(
  parameter int CYCLES = `TSCHED_TICK_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run_en,
  output logic      tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } tsched_tick_t;

  tsched_tick_t st_reg;
  tsched_tick_t st_next;

  // Count halts outside run mode, so stopped time is never counted
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (run_en)
    begin
      if (st_reg.cnt == LAST)
      begin
        st_next.cnt = '0;
        st_next.tick = 1'b1;
      end
      else
        st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;

  a_tick_run_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !run_en |=> !tick) else $error("tick outside run mode"); // R5
endmodule

// ===== rtl/tsched_top.sv
// Task request detection, priority queue and preemption dispatcher
// with an APB register slave. Assumes one 40 MHz clock, raw trigger
// pins, and an execution engine on pclk that pulses done signals.
`timescale 1ns/1ps
`include "tsched_consts.svh"

// Notes on behaviour
// R1: every task holds a priority 2..7 used to pick among pending ones
// R2: periodic tasks are numbered 0..15, each number used once
// R3: periodic task requests once per period of 1..4294967295 ms
// R4: periodic request dropped while that task runs or is pending
// R5: periodic timers advance only in run mode, never across power off
// R6: input tasks are 16..23, each tied to one contact 8..15
// R7: input task starts on rising, falling or either edge
// R8: eight trigger contacts, the ninth to sixteenth inputs
// R9: input edge request dropped while that task runs or is pending
// R10: edge monitoring only in run mode, none in stop
// R11: qualifying edge raises a request within about 50 us
// R12: a request during the scan suspends it and starts the task
// R13: simultaneous requests start the higher priority, other waits
// R14: on task end, pending requests are granted before scan resumes
// R15: higher priority preempts a running task, which later resumes
// R16: with nothing pending, the suspended scan resumes where stopped
// R17: internal conditions checked at scan end, run before next scan
// R18: new scan starts only after scan and end-of-scan tasks finish
// R19: init phase ends on the init done command, then scan runs
// R20: priority 2 is most urgent, larger values less urgent
// R21: equal priorities are granted in order of occurrence; once waiting ages saturate at 255 cycles, the lowest task number wins
// R22: global and per-task allow and block commands gate task starts
// R23: after power-up every task is allowed
// R24: periodic timers count 1 ms ticks, reload, pulse one request
module tsched_top #(
  parameter int NP          = 16,
  parameter int NE          = 8,
  parameter int NI          = 16,
  parameter int DEPTH       = 6,
  parameter int TICK_CYCLES = `TSCHED_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [NE-1:0] trigger_input_contacts,
  input  wire logic [NI-1:0] int_cond,
  input  wire logic        scan_end,
  input  wire logic        task_done,
  input  wire logic        init_done,
  output logic             task_start,
  output logic             task_resume,
  output logic      [5:0]  task_id,
  output logic             scan_start,
  output logic             scan_resume,
  output logic             scan_hold,
  output logic             init_phase,
  output logic             run_mode
);
  localparam int NT = NP + NE + NI; // R2
  localparam int SW = $clog2(NE);

  typedef struct packed {
    tsched_pkg::tsched_phase_t phase;
    logic                      run;
    logic                      g_allow;
    logic [NT-1:0]             allow;
    logic [NT-1:0]             pend;
    logic [NT-1:0]             act;
    logic [NI-1:0]             ien;
    logic [NT-1:0][2:0]        prio;
    logic [NT-1:0][7:0]        age;
    logic [NP-1:0][31:0]       period;
    logic [NP-1:0][31:0]       cnt;
    logic [NE-1:0][1:0]        emode;
    logic [NE-1:0][SW-1:0]     esel;
    logic                      cur_v;
    logic [5:0]                cur_id;
    logic [2:0]                cur_p;
    logic [DEPTH-1:0][5:0]     stk_id;
    logic [DEPTH-1:0][2:0]     stk_p;
    logic [2:0]                sp;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      t_start;
    logic                      t_resume;
    logic                      s_start;
    logic                      s_resume;
    logic                      s_hold;
    logic                      init;
  } tsched_state_t;

  tsched_state_t st_reg;
  tsched_state_t st_next;
  logic          tick;
  logic [NE-1:0] edge_req;
  logic [NT-1:0] req;
  logic [NT-1:0] busy;
  logic          best_v;
  logic [5:0]    best_id;
  logic [2:0]    best_p;
  logic [7:0]    best_age;
  logic          do_start;
  logic [11:0]   off;
  logic          hit;
  logic [31:0]   rd;
  logic [9:0]    idx;

  // Timebase stalls outside run mode
  tsched_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run_en  (st_reg.run),
    .tick    (tick)
  ); // R5

  // Trigger contacts feed input tasks NP..NP+NE-1
  tsched_edge #(.NCH(NE)) u_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .contact_pin (trigger_input_contacts),
    .run_en      (st_reg.run),
    .cfg_mode    (st_reg.emode),
    .cfg_sel     (st_reg.esel),
    .edge_req    (edge_req)
  ); // R6 R8

  // Register slave, request capture, queue and dispatcher
  always_comb
  begin
    st_next = st_reg;
    req = '0;
    busy = st_reg.pend | st_reg.act;
    best_v = 1'b0;
    best_id = 6'h00;
    best_p = `TSCHED_PRIO_MAX;
    best_age = 8'h00;
    do_start = 1'b0;
    hit = 1'b1;
    rd = 32'h0000_0000;
    idx = 10'h000;
    off = 12'h000;
    st_next.t_start = 1'b0;
    st_next.t_resume = 1'b0;
    st_next.s_start = 1'b0;
    st_next.s_resume = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;

    // Decode: fixed words first, then the three tables
    if (paddr >= `TSCHED_ECFG_BASE)
      off = paddr - `TSCHED_ECFG_BASE;
    else if (paddr >= `TSCHED_PERIOD_BASE)
      off = paddr - `TSCHED_PERIOD_BASE;
    else if (paddr >= `TSCHED_PRIO_BASE)
      off = paddr - `TSCHED_PRIO_BASE;
    idx = off[11:2];
    case (paddr)
      `TSCHED_CTRL_OFS:     rd = {31'h0, st_reg.run};
      `TSCHED_CMD_OFS:      rd = {31'h0, st_reg.g_allow};
      `TSCHED_STATUS_OFS:   rd = {13'h0, st_reg.sp, st_reg.cur_p,
                                  st_reg.cur_id, st_reg.cur_v,
                                  st_reg.s_hold, 2'h0, st_reg.phase};
      `TSCHED_PEND_LO_OFS:  rd = st_reg.pend[31:0];
      `TSCHED_PEND_HI_OFS:  rd = 32'(st_reg.pend[NT-1:32]);
      `TSCHED_ALLOW_LO_OFS: rd = st_reg.allow[31:0];
      `TSCHED_ALLOW_HI_OFS: rd = 32'(st_reg.allow[NT-1:32]);
      `TSCHED_IEN_OFS:      rd = 32'(st_reg.ien);
      default:
      begin
        if (paddr[1:0] != 2'h0)
          hit = 1'b0;
        else if (paddr >= `TSCHED_ECFG_BASE && idx < 10'(NE))
          rd = 32'({st_reg.esel[idx], st_reg.emode[idx]});
        else if (paddr >= `TSCHED_PERIOD_BASE && paddr < `TSCHED_ECFG_BASE
                 && idx < 10'(NP))
          rd = st_reg.period[idx];
        else if (paddr >= `TSCHED_PRIO_BASE
                 && paddr < `TSCHED_PERIOD_BASE && idx < 10'(NT))
          rd = 32'(st_reg.prio[idx]);
        else
          hit = 1'b0;
      end
    endcase

    // Answer is prepared in the setup cycle, so access ends in one
    if (psel && !penable)
    begin
      st_next.pready = 1'b1;
      st_next.pslverr = !hit;
      st_next.prdata = hit ? rd : 32'h0000_0000;
    end

    // Writes land only at the completing access edge
    if (psel && penable && st_reg.pready && pwrite && hit)
    begin
      case (paddr)
        `TSCHED_CTRL_OFS: st_next.run = pwdata[0];
        `TSCHED_CMD_OFS:
        begin
          if (pwdata[`TSCHED_CMD_TALLOW] && pwdata[5:0] < 6'(NT))
            st_next.allow[pwdata[5:0]] = 1'b1; // R22
          if (pwdata[`TSCHED_CMD_TBLOCK] && pwdata[5:0] < 6'(NT))
            st_next.allow[pwdata[5:0]] = 1'b0; // R22
          if (pwdata[`TSCHED_CMD_GALLOW])
            st_next.g_allow = 1'b1; // R22
          if (pwdata[`TSCHED_CMD_GBLOCK])
            st_next.g_allow = 1'b0; // R22
        end
        `TSCHED_IEN_OFS: st_next.ien = pwdata[NI-1:0];
        default:
        begin
          if (paddr >= `TSCHED_ECFG_BASE)
          begin
            st_next.emode[idx] = pwdata[`TSCHED_ECFG_MODE_LSB +: 2]; // R7
            st_next.esel[idx] = pwdata[`TSCHED_ECFG_SEL_LSB +: SW]; // R6
          end
          else if (paddr >= `TSCHED_PERIOD_BASE)
          begin
            st_next.period[idx] = pwdata; // R3
            st_next.cnt[idx] = 32'h0000_0000;
          end
          else if (paddr >= `TSCHED_PRIO_BASE
                   && pwdata[2:0] >= `TSCHED_PRIO_MIN)
            st_next.prio[idx] = pwdata[2:0]; // R1
        end
      endcase
    end

    // Periodic timers: zero period leaves the task unconfigured
    for (int i = 0; i < NP; i++)
    begin
      if (tick && st_reg.period[i] != 32'h0000_0000)
      begin
        if (st_reg.cnt[i] >= st_reg.period[i] - 32'h1)
        begin
          st_next.cnt[i] = 32'h0000_0000; // R24
          req[i] = 1'b1; // R3
        end
        else
          st_next.cnt[i] = st_reg.cnt[i] + 32'h1; // R24
      end
    end
    req[NP +: NE] = edge_req; // R11

    // Internal conditions sampled only at the end of a scan
    if (st_reg.phase == tsched_pkg::TSCHED_PH_SCAN && scan_end
        && !st_reg.s_hold)
    begin
      st_next.phase = tsched_pkg::TSCHED_PH_END;
      req[NP+NE +: NI] = int_cond & st_reg.ien; // R17
    end
    if (st_reg.init)
      req = '0;

    // Busy tasks drop new requests; age orders equal priorities
    for (int i = 0; i < NT; i++)
    begin
      if (req[i] && !busy[i])
      begin
        st_next.pend[i] = 1'b1; // R4 R9
        st_next.age[i] = 8'h00;
      end
      else if (st_reg.pend[i] && st_reg.age[i] != 8'hff)
        st_next.age[i] = st_reg.age[i] + 8'h01; // R21
    end

    // Lowest value wins, oldest on a tie, lowest number last
    for (int i = 0; i < NT; i++)
    begin
      if (st_reg.pend[i] && st_reg.allow[i] && st_reg.g_allow) // R22
      begin
        if (!best_v || st_reg.prio[i] < best_p // R20 R13
            || (st_reg.prio[i] == best_p && st_reg.age[i] > best_age)) // R21
        begin
          best_v = 1'b1;
          best_id = 6'(i);
          best_p = st_reg.prio[i];
          best_age = st_reg.age[i];
        end
      end
    end

    // Dispatcher
    if (st_reg.init)
    begin
      if (init_done)
      begin
        st_next.init = 1'b0; // R19
        st_next.phase = tsched_pkg::TSCHED_PH_SCAN;
        st_next.s_start = 1'b1; // R19
      end
    end
    else if (task_done && st_reg.cur_v)
    begin
      st_next.act[st_reg.cur_id] = 1'b0;
      if (best_v && (st_reg.sp == 3'h0
          || best_p < st_reg.stk_p[st_reg.sp - 3'h1]))
        do_start = 1'b1; // R14
      else if (st_reg.sp != 3'h0)
      begin
        st_next.sp = st_reg.sp - 3'h1;
        st_next.cur_id = st_reg.stk_id[st_reg.sp - 3'h1]; // R15
        st_next.cur_p = st_reg.stk_p[st_reg.sp - 3'h1];
        st_next.t_resume = 1'b1; // R15
      end
      else
      begin
        st_next.cur_v = 1'b0;
        if (st_reg.s_hold)
        begin
          st_next.s_hold = 1'b0;
          st_next.s_resume = 1'b1; // R16
        end
      end
    end
    else if (best_v && (!st_reg.cur_v
             || (best_p < st_reg.cur_p && st_reg.sp < 3'(DEPTH))))
    begin
      do_start = 1'b1;
      if (st_reg.cur_v)
      begin
        st_next.stk_id[st_reg.sp] = st_reg.cur_id; // R15
        st_next.stk_p[st_reg.sp] = st_reg.cur_p;
        st_next.sp = st_reg.sp + 3'h1;
      end
      else if (st_reg.phase == tsched_pkg::TSCHED_PH_SCAN)
        st_next.s_hold = 1'b1; // R12
    end
    else if (!st_reg.cur_v && st_reg.phase == tsched_pkg::TSCHED_PH_END)
    begin
      st_next.phase = tsched_pkg::TSCHED_PH_SCAN; // R18
      st_next.s_start = 1'b1;
    end

    if (do_start)
    begin
      st_next.pend[best_id] = 1'b0;
      st_next.act[best_id] = 1'b1;
      st_next.cur_v = 1'b1;
      st_next.cur_id = best_id;
      st_next.cur_p = best_p;
      st_next.t_start = 1'b1; // R13
    end
  end

  // Reset: everything allowed, init phase, lowest urgency everywhere
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.phase <= tsched_pkg::TSCHED_PH_INIT;
      st_reg.init <= 1'b1;
      st_reg.g_allow <= 1'b1; // R23
      st_reg.allow <= '1; // R23
      st_reg.prio <= {NT{`TSCHED_PRIO_RST}};
      st_reg.period <= {NP{`TSCHED_PERIOD_RST}};
    end
    else
      st_reg <= st_next;
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign task_start = st_reg.t_start;
  assign task_resume = st_reg.t_resume;
  assign task_id = st_reg.cur_id;
  assign scan_start = st_reg.s_start;
  assign scan_resume = st_reg.s_resume;
  assign scan_hold = st_reg.s_hold;
  assign init_phase = st_reg.init;
  assign run_mode = st_reg.run;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_done;
    task_done && st_reg.cur_v && !best_v && st_reg.sp == 3'h0
      && st_reg.s_hold && !st_reg.init;
  endsequence
  sequence s_scan_back;
    scan_resume && !scan_hold ##1 !scan_resume;
  endsequence

  a_prio_legal_range: assert property (st_reg.cur_v |->
    st_reg.cur_p >= `TSCHED_PRIO_MIN) else $error("bad priority"); // R1
  a_busy_drops_req: assert property (
    ((st_reg.pend & ~$past(st_reg.pend)) & $past(busy)) == '0)
    else $error("request queued for busy task"); // R4
  a_scan_preempted: assert property (
    st_reg.phase == tsched_pkg::TSCHED_PH_SCAN && !st_reg.cur_v
    && best_v && !task_done && !st_reg.init |=> task_start && scan_hold)
    else $error("scan not suspended"); // R12
  a_best_started: assert property (task_start |->
    st_reg.cur_p == $past(best_p) && st_reg.cur_id == $past(best_id))
    else $error("wrong task granted"); // R13
  a_task_preempt: assert property (st_reg.cur_v && best_v && !task_done
    && best_p < st_reg.cur_p && st_reg.sp < 3'(DEPTH) && !st_reg.init
    |=> task_start && st_reg.sp == $past(st_reg.sp) + 3'h1)
    else $error("no preemption"); // R15
  a_scan_resumes: assert property (s_last_done |=> s_scan_back)
    else $error("scan not resumed"); // R16
  a_scan_after_end: assert property (scan_start && !$past(st_reg.init)
    |-> $past(!st_reg.cur_v && st_reg.phase == tsched_pkg::TSCHED_PH_END))
    else $error("scan started early"); // R18
  a_init_no_task: assert property (init_phase && !init_done |=>
    init_phase && !task_start) else $error("task in init phase"); // R19
  a_block_all_start: assert property (!st_reg.g_allow |=> !task_start)
    else $error("start while blocked"); // R22
  a_edge_bound: assert property ($rose(edge_req[0]) && !busy[NP]
    && !st_reg.init |=> st_reg.pend[NP])
    else $error("edge request not queued"); // R11
  a_edge_cyc_fits: assert property (st_reg.run && !st_reg.init
    && st_reg.emode[0] == 2'h1 && st_reg.esel[0] == '0 && !busy[NP]
    && $rose(u_edge.st_reg.s2[0]) |=> ##1 st_reg.pend[NP])
    else $error("edge request too slow"); // R11
endmodule
